// >>> shared/pptc_regs.svh
// Register offsets, field positions and reset values of the port control bank
// Assumes byte-wide registers reached through a simple byte access port
//
// Operation
// - Control bit 7 set enables broadcast storm limiting on that port's ingress.
// - Control bit 6 set enables DiffServ code point priority classification on ingress.
// - Control bit 5 set enables 802.1p user priority classification on ingress.
// - Without successful classification, bit 4 selects high, else low priority.
// - All methods may be on; OR of 802.1p and DiffServ overrides port priority.
// - Bit 3 set caps packet user priority at the port default tag priority.
// - Egress bit 2 set adds a tag to untagged packets, tagged ones untouched.
// - Added tag carries the ingress port's default VLAN identifier.
// - Three port control registers share one layout at different addresses.
// - Three byte-wide read-write scratch registers without function, reset to zero.
// - Reserved byte at 0x0C has no function and reads zero.
`ifndef PPTC_REGS_SVH
`define PPTC_REGS_SVH

`define PPTC_OFS_RSVD      8'h0C
`define PPTC_OFS_SCRATCH1  8'h0D
`define PPTC_OFS_SCRATCH2  8'h0E
`define PPTC_OFS_SCRATCH3  8'h0F
`define PPTC_OFS_PORT1     8'h10
`define PPTC_OFS_PORT2     8'h20
`define PPTC_OFS_PORT3     8'h30

`define PPTC_BIT_STORM     7
`define PPTC_BIT_DSCP      6
`define PPTC_BIT_TAGPRI    5
`define PPTC_BIT_PORTPRI   4
`define PPTC_BIT_CEILING   3
`define PPTC_BIT_TAGADD    2

`define PPTC_RST_SCRATCH   8'h00
`define PPTC_RST_RSVD      8'h00
`define PPTC_RST_CTRL      8'h00

`endif

// >>> shared/pptc_pkg.sv
// Types shared by the port control bank and its datapath helpers
// Assumes nothing of its surroundings
package pptc_pkg;
	typedef logic [7:0]  pptc_byte_t;
	typedef logic [1:0]  pptc_port_t;
	typedef logic [2:0]  pptc_prio_t;
	typedef logic [11:0] pptc_vid_t;
endpackage

// >>> rtl/pptc_classify.sv
// Ingress priority classification for one packet at a time
// Assumes the control byte of the ingress port is presented with the request
`timescale 1ns/1ps
`default_nettype none
`include "pptc_regs.svh"
module pptc_classify
	import pptc_pkg::*;
#(
	parameter pptc_prio_t HIGH_MIN = 3'h4
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Port settings
	input  wire pptc_byte_t ctrl,
	input  wire pptc_prio_t dflt_prio,
	// Packet request
	input  wire logic       ing_req,
	input  wire logic       ing_tagged,
	input  wire pptc_prio_t ing_user_prio,
	input  wire logic       ing_ip,
	input  wire logic       ing_dscp_high,
	// Result
	output logic            ing_done,
	output logic            ing_high_prio,
	output pptc_prio_t      ing_prio_out,
	output logic            ing_storm_limit
);
	logic       done_reg, done_next;
	logic       high_reg, high_next;
	logic       storm_reg, storm_next;
	pptc_prio_t prio_reg, prio_next;
	logic       tag_ok, ds_ok;

	always_comb begin
		tag_ok = ctrl[`PPTC_BIT_TAGPRI] && ing_tagged;
		ds_ok = ctrl[`PPTC_BIT_DSCP] && ing_ip;
		prio_next = ing_user_prio;
		if (ctrl[`PPTC_BIT_CEILING] && ing_user_prio > dflt_prio) begin
			prio_next = dflt_prio;
		end
		if (tag_ok || ds_ok) begin
			high_next = (tag_ok && prio_next >= HIGH_MIN) || (ds_ok && ing_dscp_high);
		end else begin
			high_next = ctrl[`PPTC_BIT_PORTPRI];
		end
		storm_next = ctrl[`PPTC_BIT_STORM];
		done_next = ing_req;
		if (!ing_req) begin
			high_next = high_reg;
			prio_next = prio_reg;
			storm_next = storm_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
			high_reg <= 1'b0;
			prio_reg <= 3'h0;
			storm_reg <= 1'b0;
		end else begin
			done_reg <= done_next;
			high_reg <= high_next;
			prio_reg <= prio_next;
			storm_reg <= storm_next;
		end
	end

	assign ing_done = done_reg;
	assign ing_high_prio = high_reg;
	assign ing_prio_out = prio_reg;
	assign ing_storm_limit = storm_reg;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_storm_follows_bit: assert property (ing_req |=> ing_storm_limit == $past(ctrl[7]))
		else $error("storm limit does not follow control bit");
	chk_dscp_high: assert property (ing_req && ctrl[6] && ing_ip && ing_dscp_high |=> ing_high_prio)
		else $error("diffserv high packet not high");
	chk_tag_off: assert property (ing_req && !ctrl[5] && !(ctrl[6] && ing_ip) |=> ing_high_prio == $past(ctrl[4]))
		else $error("disabled tag class still used");
	chk_port_fallback: assert property (ing_req && !ctrl[5] && !ctrl[6] |=> ing_high_prio == $past(ctrl[4]))
		else $error("port priority fallback wrong");
	chk_or_overrides: assert property (ing_req && ctrl[4] && ctrl[6] && ing_ip && !ing_dscp_high && !ctrl[5] |=> !ing_high_prio)
		else $error("classified result did not override port priority");
	chk_ceiling_cap: assert property (ing_req && ctrl[3] |=> ing_prio_out <= $past(dflt_prio))
		else $error("user priority above ceiling");
	chk_no_ceiling: assert property (ing_req && !ctrl[3] |=> ing_prio_out == $past(ing_user_prio))
		else $error("priority changed without ceiling");
endmodule
`default_nettype wire

// >>> rtl/pptc_egress_tag.sv
// Egress tag insertion decision for one outgoing packet
// Assumes the egress port control byte and ingress port default VID are given
`timescale 1ns/1ps
`default_nettype none
`include "pptc_regs.svh"
module pptc_egress_tag
	import pptc_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Settings
	input  wire pptc_byte_t ctrl,
	input  wire pptc_vid_t  src_vid,
	// Packet request
	input  wire logic       eg_req,
	input  wire logic       eg_tagged,
	// Result
	output logic            eg_done,
	output logic            eg_add_tag,
	output pptc_vid_t       eg_vid
);
	logic      done_reg, done_next;
	logic      add_reg, add_next;
	pptc_vid_t vid_reg, vid_next;

	always_comb begin
		done_next = eg_req;
		add_next = add_reg;
		vid_next = vid_reg;
		if (eg_req) begin
			add_next = ctrl[`PPTC_BIT_TAGADD] && !eg_tagged;
			vid_next = src_vid;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
			add_reg <= 1'b0;
			vid_reg <= 12'h000;
		end else begin
			done_reg <= done_next;
			add_reg <= add_next;
			vid_reg <= vid_next;
		end
	end

	assign eg_done = done_reg;
	assign eg_add_tag = add_reg;
	assign eg_vid = vid_reg;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_tag_added: assert property (eg_req |=> eg_add_tag == $past(ctrl[2] && !eg_tagged))
		else $error("tag insertion decision wrong");
	chk_tagged_kept: assert property (eg_req && eg_tagged |=> !eg_add_tag)
		else $error("tag added to tagged packet");
	chk_tag_vid: assert property (eg_req |=> eg_vid == $past(src_vid))
		else $error("added tag carries wrong VID");
endmodule
`default_nettype wire

// >>> rtl/pptc_bank_top.sv
// Port control register bank with ingress classification and egress tagging
// Assumes a synchronous byte access port and straps stable around reset
`timescale 1ns/1ps
`default_nettype none
`include "pptc_regs.svh"
module pptc_bank_top
	import pptc_pkg::*;
#(
	parameter pptc_prio_t HIGH_MIN = 3'h4
) (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// Register access
	input  wire pptc_byte_t           reg_addr,
	input  wire logic                 reg_wr,
	input  wire pptc_byte_t           reg_wdata,
	input  wire logic                 reg_rd,
	output pptc_byte_t                reg_rdata,
	// Strap pins
	input  wire logic                 port1_tag_priority_strap,
	input  wire logic                 port2_tag_priority_strap,
	input  wire logic                 port3_tag_priority_strap,
	input  wire logic                 port1_port_priority_strap,
	input  wire logic                 port2_port_priority_strap,
	input  wire logic                 port3_port_priority_strap,
	input  wire logic                 port1_tag_add_strap,
	input  wire logic                 port2_tag_add_strap,
	input  wire logic                 port3_tag_add_strap,
	// Port default tags
	input  wire logic [2:0][2:0]      dflt_prio,
	input  wire logic [2:0][11:0]     dflt_vid,
	// Ingress request
	input  wire logic                 ing_req,
	input  wire pptc_port_t           ing_port,
	input  wire logic                 ing_tagged,
	input  wire pptc_prio_t           ing_user_prio,
	input  wire logic                 ing_ip,
	input  wire logic                 ing_dscp_high,
	// Ingress result
	output logic                      ing_done,
	output logic                      ing_high_prio,
	output pptc_prio_t                ing_prio_out,
	output logic                      ing_storm_limit,
	// Egress request
	input  wire logic                 eg_req,
	input  wire pptc_port_t           eg_port,
	input  wire pptc_port_t           eg_src_port,
	input  wire logic                 eg_tagged,
	// Egress result
	output logic                      eg_done,
	output logic                      eg_add_tag,
	output pptc_vid_t                 eg_vid
);

	////////////////////////////////////////////////////////////////////////////
	// Parameter check

	if (HIGH_MIN == 3'h0) begin : g_bad_high_min
		$error("HIGH_MIN of zero makes every tagged packet high");
	end

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [1:0] port_of_addr(input pptc_byte_t a);
		unique case (a)
			`PPTC_OFS_PORT1: port_of_addr = 2'd0;
			`PPTC_OFS_PORT2: port_of_addr = 2'd1;
			`PPTC_OFS_PORT3: port_of_addr = 2'd2;
			default:         port_of_addr = 2'd3;
		endcase
	endfunction

	function automatic logic [1:0] scratch_of_addr(input pptc_byte_t a);
		unique case (a)
			`PPTC_OFS_SCRATCH1: scratch_of_addr = 2'd0;
			`PPTC_OFS_SCRATCH2: scratch_of_addr = 2'd1;
			`PPTC_OFS_SCRATCH3: scratch_of_addr = 2'd2;
			default:            scratch_of_addr = 2'd3;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Strap synchronisers

	logic [2:0] tp_s1, tp_s2;
	logic [2:0] pp_s1, pp_s2;
	logic [2:0] ta_s1, ta_s2;

	always_ff @(posedge core_clk) begin
		tp_s1 <= {port3_tag_priority_strap, port2_tag_priority_strap, port1_tag_priority_strap};
		pp_s1 <= {port3_port_priority_strap, port2_port_priority_strap, port1_port_priority_strap};
		ta_s1 <= {port3_tag_add_strap, port2_tag_add_strap, port1_tag_add_strap};
		tp_s2 <= tp_s1;
		pp_s2 <= pp_s1;
		ta_s2 <= ta_s1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register file

	pptc_byte_t scratch_reg [3];
	pptc_byte_t scratch_next [3];
	pptc_byte_t ctrl_reg [3];
	pptc_byte_t ctrl_next [3];
	pptc_byte_t rdata_reg, rdata_next;
	logic [1:0] wr_port, wr_scr, rd_port, rd_scr;

	always_comb begin
		wr_port = port_of_addr(reg_addr);
		wr_scr = scratch_of_addr(reg_addr);
		rd_port = wr_port;
		rd_scr = wr_scr;
		for (int i = 0; i < 3; i++) begin
			scratch_next[i] = scratch_reg[i];
			ctrl_next[i] = ctrl_reg[i];
			if (reg_wr && wr_scr == 2'(i)) begin
				scratch_next[i] = reg_wdata;
			end
			if (reg_wr && wr_port == 2'(i)) begin
				ctrl_next[i] = reg_wdata;
			end
		end
		rdata_next = rdata_reg;
		if (reg_rd) begin
			if (rd_scr != 2'd3) begin
				rdata_next = scratch_reg[rd_scr];
			end else if (rd_port != 2'd3) begin
				rdata_next = ctrl_reg[rd_port];
			end else begin
				rdata_next = `PPTC_RST_RSVD;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++) begin
				scratch_reg[i] <= `PPTC_RST_SCRATCH;
				ctrl_reg[i] <= `PPTC_RST_CTRL;
				ctrl_reg[i][`PPTC_BIT_TAGPRI] <= tp_s2[i];
				ctrl_reg[i][`PPTC_BIT_PORTPRI] <= pp_s2[i];
				ctrl_reg[i][`PPTC_BIT_TAGADD] <= ta_s2[i];
			end
			rdata_reg <= 8'h00;
		end else begin
			for (int i = 0; i < 3; i++) begin
				scratch_reg[i] <= scratch_next[i];
				ctrl_reg[i] <= ctrl_next[i];
			end
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// Per-port selection

	pptc_byte_t ing_ctrl, eg_ctrl;
	pptc_prio_t ing_dflt;
	pptc_vid_t  src_vid;

	always_comb begin
		ing_ctrl = 8'h00;
		ing_dflt = 3'h0;
		eg_ctrl = 8'h00;
		src_vid = 12'h000;
		if (ing_port != 2'd3) begin
			ing_ctrl = ctrl_reg[ing_port];
			ing_dflt = dflt_prio[ing_port];
		end
		if (eg_port != 2'd3) begin
			eg_ctrl = ctrl_reg[eg_port];
		end
		if (eg_src_port != 2'd3) begin
			src_vid = dflt_vid[eg_src_port];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Datapath helpers

	pptc_classify #(
		.HIGH_MIN (HIGH_MIN)
	) u_classify (
		.core_clk        (core_clk),
		.rst_n           (rst_n),
		.ctrl            (ing_ctrl),
		.dflt_prio       (ing_dflt),
		.ing_req         (ing_req),
		.ing_tagged      (ing_tagged),
		.ing_user_prio   (ing_user_prio),
		.ing_ip          (ing_ip),
		.ing_dscp_high   (ing_dscp_high),
		.ing_done        (ing_done),
		.ing_high_prio   (ing_high_prio),
		.ing_prio_out    (ing_prio_out),
		.ing_storm_limit (ing_storm_limit)
	);

	pptc_egress_tag u_egress (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.ctrl       (eg_ctrl),
		.src_vid    (src_vid),
		.eg_req     (eg_req),
		.eg_tagged  (eg_tagged),
		.eg_done    (eg_done),
		.eg_add_tag (eg_add_tag),
		.eg_vid     (eg_vid)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_write_port(logic [7:0] ofs);
		reg_wr && !reg_rd && reg_addr == ofs;
	endsequence

	sequence s_read_back(logic [7:0] ofs);
		##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == ofs ##1 1'b1;
	endsequence

	chk_port2_layout: assert property (s_write_port(8'h20) ##0 s_read_back(8'h20)
		|-> reg_rdata == $past(reg_wdata, 3))
		else $error("port two control did not read back");
	chk_port3_apart: assert property (reg_wr && reg_addr == 8'h30 |=> ctrl_reg[0] == $past(ctrl_reg[0]))
		else $error("port three write reached port one");
	chk_scratch_hold: assert property (reg_wr && reg_addr == 8'h0E |=> scratch_reg[1] == $past(reg_wdata))
		else $error("scratch two write lost");
	chk_scratch_zero: assert property (@(posedge core_clk) disable iff (1'b0)
		!rst_n |=> scratch_reg[0] == 8'h00 && scratch_reg[2] == 8'h00)
		else $error("scratch not cleared by reset");
	chk_rsvd_reads: assert property (reg_rd && reg_addr == 8'h0C |=> reg_rdata == 8'h00)
		else $error("reserved byte not zero");
	chk_strap_load: assert property (@(posedge core_clk) disable iff (1'b0)
		!rst_n && $past(!rst_n, 2) |=> ctrl_reg[1][5] == $past(tp_s2[1]) && ctrl_reg[2][4] == $past(pp_s2[2])
		&& ctrl_reg[0][2] == $past(ta_s2[0]) && ctrl_reg[0][7:6] == 2'b00 && ctrl_reg[0][3] == 1'b0)
		else $error("control reset value wrong");

	////////////////////////////////////////////////////////////////////////////
	// Register bank checks

	chk_scratch1_write: assert property (reg_wr && reg_addr == 8'h0D
		|=> scratch_reg[0] == $past(reg_wdata))
		else $error("scratch one write lost");
	chk_scratch3_write: assert property (reg_wr && reg_addr == 8'h0F
		|=> scratch_reg[2] == $past(reg_wdata))
		else $error("scratch three write lost");
	chk_scratch_read: assert property (reg_rd && !reg_wr && reg_addr == 8'h0F
		|=> reg_rdata == $past(scratch_reg[2]))
		else $error("scratch three read wrong");
	chk_port1_write: assert property (reg_wr && reg_addr == 8'h10
		|=> ctrl_reg[0] == $past(reg_wdata))
		else $error("port one control write lost");
	chk_port3_write: assert property (reg_wr && reg_addr == 8'h30
		|=> ctrl_reg[2] == $past(reg_wdata))
		else $error("port three control write lost");
	chk_port1_read: assert property (reg_rd && !reg_wr && reg_addr == 8'h10
		|=> reg_rdata == $past(ctrl_reg[0]))
		else $error("port one control read wrong");
	chk_rsvd_write: assert property (reg_wr && reg_addr == 8'h0C
		|=> ctrl_reg[0] == $past(ctrl_reg[0]) && scratch_reg[0] == $past(scratch_reg[0]))
		else $error("reserved byte write changed state");
	chk_rdata_hold: assert property (!reg_rd
		|=> $stable(reg_rdata))
		else $error("read data changed without read");
	chk_strap_rest: assert property (@(posedge core_clk) disable iff (1'b0)
		!rst_n && $past(!rst_n, 2)
		|=> ctrl_reg[0][5] == $past(tp_s2[0]) && ctrl_reg[2][5] == $past(tp_s2[2])
		&& ctrl_reg[0][4] == $past(pp_s2[0]) && ctrl_reg[1][4] == $past(pp_s2[1])
		&& ctrl_reg[1][2] == $past(ta_s2[1]) && ctrl_reg[2][2] == $past(ta_s2[2]))
		else $error("strap reset value wrong");
	chk_ctrl_rest_zero: assert property (@(posedge core_clk) disable iff (1'b0)
		!rst_n
		|=> ctrl_reg[0][1:0] == 2'h0 && ctrl_reg[1][7:6] == 2'h0 && ctrl_reg[1][3] == 1'b0
		&& ctrl_reg[1][1:0] == 2'h0 && ctrl_reg[2][7:6] == 2'h0 && ctrl_reg[2][3] == 1'b0
		&& ctrl_reg[2][1:0] == 2'h0)
		else $error("control bits without strap not zero");

	////////////////////////////////////////////////////////////////////////////
	// Port selection checks

	chk_ing_storm_port: assert property (ing_req && ing_port != 2'h3
		|=> ing_storm_limit == $past(ctrl_reg[ing_port][7]))
		else $error("storm limit not from ingress port");
	chk_ing_no_port: assert property (ing_req && ing_port == 2'h3
		|=> !ing_high_prio && !ing_storm_limit)
		else $error("no port request not low priority");
	chk_ing_ceiling_port: assert property (ing_req && ing_port != 2'h3 && ctrl_reg[ing_port][3]
		|=> ing_prio_out <= $past(dflt_prio[ing_port]))
		else $error("ceiling not from ingress port");
	chk_eg_port_bit: assert property (eg_req && eg_port != 2'h3 && !eg_tagged
		|=> eg_add_tag == $past(ctrl_reg[eg_port][2]))
		else $error("tag insertion not from egress port");
	chk_eg_no_port: assert property (eg_req && eg_port == 2'h3
		|=> !eg_add_tag)
		else $error("tag added for no egress port");
	chk_eg_src_vid: assert property (eg_req && eg_src_port != 2'h3
		|=> eg_vid == $past(dflt_vid[eg_src_port]))
		else $error("added tag VID not from source port");
	chk_eg_no_src: assert property (eg_req && eg_src_port == 2'h3
		|=> eg_vid == 12'h000)
		else $error("VID not zero without source port");

endmodule
`default_nettype wire

// >>> sim/pptc_bank_top_tb.sv
// Self-checking bench for the port control register bank
// Assumes the bank top alone; bench drives all ports at the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "pptc_regs.svh"
module pptc_bank_top_tb import pptc_pkg::*;;
	localparam pptc_prio_t high_min = 3'h4;
	logic                 core_clk;
	logic                 rst_n;
	pptc_byte_t           reg_addr, reg_wdata, reg_rdata;
	logic                 reg_wr, reg_rd;
	logic [8:0]           st;
	logic [2:0][2:0]      dflt_prio;
	logic [2:0][11:0]     dflt_vid;
	logic                 ing_req, ing_tagged, ing_ip, ing_dscp_high;
	pptc_port_t           ing_port, eg_port, eg_src_port;
	pptc_prio_t           ing_user_prio, ing_prio_out;
	logic                 ing_done, ing_high_prio, ing_storm_limit;
	logic                 eg_req, eg_tagged, eg_done, eg_add_tag;
	pptc_vid_t            eg_vid;
	int                   n_errors, num_checks, seed_val;
	pptc_byte_t           sh [0:3];
	pptc_byte_t           scr [0:2];
	pptc_byte_t           addrs [9];

	always #2 core_clk = ~core_clk;

	pptc_bank_top #(.HIGH_MIN(high_min)) pptc_bank_top_i (
		.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.port1_tag_priority_strap(st[0]), .port2_tag_priority_strap(st[1]), .port3_tag_priority_strap(st[2]),
		.port1_port_priority_strap(st[3]), .port2_port_priority_strap(st[4]), .port3_port_priority_strap(st[5]),
		.port1_tag_add_strap(st[6]), .port2_tag_add_strap(st[7]), .port3_tag_add_strap(st[8]),
		.dflt_prio(dflt_prio), .dflt_vid(dflt_vid),
		.ing_req(ing_req), .ing_port(ing_port), .ing_tagged(ing_tagged), .ing_user_prio(ing_user_prio),
		.ing_ip(ing_ip), .ing_dscp_high(ing_dscp_high), .ing_done(ing_done), .ing_high_prio(ing_high_prio),
		.ing_prio_out(ing_prio_out), .ing_storm_limit(ing_storm_limit),
		.eg_req(eg_req), .eg_port(eg_port), .eg_src_port(eg_src_port), .eg_tagged(eg_tagged),
		.eg_done(eg_done), .eg_add_tag(eg_add_tag), .eg_vid(eg_vid)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Expectations
	function automatic pptc_byte_t exp_rd(pptc_byte_t a);
		case (a)
			`PPTC_OFS_SCRATCH1: return scr[0];
			`PPTC_OFS_SCRATCH2: return scr[1];
			`PPTC_OFS_SCRATCH3: return scr[2];
			`PPTC_OFS_PORT1:    return sh[0];
			`PPTC_OFS_PORT2:    return sh[1];
			`PPTC_OFS_PORT3:    return sh[2];
			default:            return 8'h00;
		endcase
	endfunction

	function automatic pptc_prio_t exp_cap(pptc_byte_t c, pptc_prio_t up, pptc_prio_t dp);
		return (c[3] && up > dp) ? dp : up;
	endfunction

	function automatic logic exp_high(pptc_byte_t c, logic tg, pptc_prio_t cp, logic ip, logic dh);
		logic t_ok;
		logic d_ok;
		t_ok = c[5] & tg;
		d_ok = c[6] & ip;
		return (t_ok | d_ok) ? ((t_ok & (cp >= high_min)) | (d_ok & dh)) : c[4];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Drivers and compare
	task automatic check(logic [11:0] seen, logic [11:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic do_reset(logic [8:0] s);
		@(negedge core_clk);
		rst_n = 1'b0;
		st = s;
		repeat (5) @(negedge core_clk);
		rst_n = 1'b1;
		for (int p = 0; p < 3; p++) begin
			sh[p] = {2'b00, s[p], s[3+p], 1'b0, s[6+p], 2'b00};
			scr[p] = 8'h00;
		end
	endtask

	task automatic reg_write(pptc_byte_t a, pptc_byte_t d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		case (a)
			`PPTC_OFS_SCRATCH1: scr[0] = d;
			`PPTC_OFS_SCRATCH2: scr[1] = d;
			`PPTC_OFS_SCRATCH3: scr[2] = d;
			`PPTC_OFS_PORT1:    sh[0] = d;
			`PPTC_OFS_PORT2:    sh[1] = d;
			`PPTC_OFS_PORT3:    sh[2] = d;
			default: ;
		endcase
	endtask

	task automatic reg_check(pptc_byte_t a);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		@(negedge core_clk);
		check(reg_rdata, exp_rd(a));
	endtask

	task automatic ing_one(pptc_port_t p, logic tg, pptc_prio_t up, logic ip, logic dh);
		pptc_byte_t c;
		pptc_prio_t dp;
		c = sh[p];
		dp = (p == 2'd3) ? 3'h0 : dflt_prio[p];
		@(negedge core_clk);
		ing_req = 1'b1;
		ing_port = p;
		ing_tagged = tg;
		ing_user_prio = up;
		ing_ip = ip;
		ing_dscp_high = dh;
		@(negedge core_clk);
		ing_req = 1'b0;
		check(ing_done, 1'b1);
		check(ing_storm_limit, c[7]);
		check(ing_high_prio, exp_high(c, tg, exp_cap(c, up, dp), ip, dh));
		check(ing_prio_out, exp_cap(c, up, dp));
		@(negedge core_clk);
		check(ing_done, 1'b0);
	endtask

	task automatic eg_one(pptc_port_t p, pptc_port_t s, logic tg);
		logic add;
		add = sh[p][2] & ~tg;
		@(negedge core_clk);
		eg_req = 1'b1;
		eg_port = p;
		eg_src_port = s;
		eg_tagged = tg;
		@(negedge core_clk);
		eg_req = 1'b0;
		check(eg_done, 1'b1);
		check(eg_add_tag, add);
		check(eg_vid, (s == 2'd3) ? 12'h000 : dflt_vid[s]);
		@(negedge core_clk);
		check(eg_done, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Sequence
	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{ing_req, ing_port, ing_tagged, ing_user_prio, ing_ip, ing_dscp_high} = '0;
		{eg_req, eg_port, eg_src_port, eg_tagged} = '0;
		st = '0;
		dflt_prio = '0;
		dflt_vid = '0;
		n_errors = 0;
		num_checks = 0;
		sh[3] = 8'h00;
		addrs = '{`PPTC_OFS_RSVD, `PPTC_OFS_SCRATCH1, `PPTC_OFS_SCRATCH2, `PPTC_OFS_SCRATCH3,
			`PPTC_OFS_PORT1, `PPTC_OFS_PORT2, `PPTC_OFS_PORT3, 8'h11, 8'hFF};
		seed_val = $urandom(6235);
		do_reset(9'($urandom));
		foreach (addrs[k]) reg_check(addrs[k]);
		foreach (addrs[k]) begin
			reg_write(addrs[k], 8'($urandom));
			reg_check(addrs[k]);
		end
		dflt_prio = 9'($urandom);
		dflt_vid = 36'({$urandom, $urandom});
		reg_write(`PPTC_OFS_PORT1, 8'hFF);
		reg_write(`PPTC_OFS_PORT2, 8'h00);
		reg_write(`PPTC_OFS_PORT3, 8'h18);
		ing_one(2'd0, 1'b1, 3'h7, 1'b1, 1'b0);
		ing_one(2'd1, 1'b1, 3'h7, 1'b1, 1'b1);
		ing_one(2'd2, 1'b0, 3'h0, 1'b0, 1'b0);
		for (int i = 0; i < 400; i++) begin
			if (i % 6 == 0)
				reg_write({2'b00, 2'($urandom % 3) + 2'd1, 4'h0}, 8'($urandom));
			ing_one(2'($urandom), 1'($urandom), 3'($urandom), 1'($urandom), 1'($urandom));
			eg_one(2'($urandom), 2'($urandom), 1'($urandom));
		end
		do_reset(~st);
		foreach (addrs[k]) reg_check(addrs[k]);
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		print_verdict();
	end
endmodule
`default_nettype wire
